// [core/isr_pkg.sv]
// constants and types for the status reporting block
package isr_pkg;

  localparam int ISR_ADDR_W = 3;
  localparam int ISR_DATA_W = 8;

  // register offsets
  localparam logic [2:0] ISR_OFS_STATUS_BYTE = 3'h0;
  localparam logic [2:0] ISR_OFS_STD_EVENT = 3'h1;
  localparam logic [2:0] ISR_OFS_STD_ENABLE = 3'h2;
  localparam logic [2:0] ISR_OFS_OPER_EVENT = 3'h3;
  localparam logic [2:0] ISR_OFS_OPER_COND = 3'h4;
  localparam logic [2:0] ISR_OFS_OPER_ENABLE = 3'h5;
  localparam logic [2:0] ISR_OFS_SRQ_ENABLE = 3'h6;
  localparam logic [2:0] ISR_OFS_CLEAR_STATUS = 3'h7;

  // standard event bit positions
  localparam int ISR_STD_POWER_ON = 7;
  localparam int ISR_STD_COMMAND_ERR = 5;
  localparam int ISR_STD_EXECUTION_ERR = 4;
  localparam int ISR_STD_QUERY_ERR = 2;
  localparam int ISR_STD_OP_COMPLETE = 0;
  localparam logic [7:0] ISR_STD_USED_MASK = 8'hB5;

  // operation event bit positions
  localparam int ISR_OPR_COMM_ERR = 7;
  localparam int ISR_OPR_CAL_ERR = 6;
  localparam int ISR_OPR_AUTOTUNE_IDLE = 5;
  localparam int ISR_OPR_NEW_READING = 4;
  localparam int ISR_OPR_LOOP_ONE_RAMP = 3;
  localparam int ISR_OPR_LOOP_TWO_RAMP = 2;
  localparam int ISR_OPR_OVERLOAD = 1;
  localparam int ISR_OPR_ALARM = 0;
  localparam logic [7:0] ISR_OPR_USED_MASK = 8'hFF;

  // status byte bit positions
  localparam int ISR_STB_OPERATION_SUMMARY = 7;
  localparam int ISR_STB_MASTER_SUMMARY = 6;
  localparam int ISR_STB_STD_EVENT_SUMMARY = 5;
  localparam int ISR_STB_MESSAGE_AVAILABLE = 4;
  localparam logic [7:0] ISR_SRE_USED_MASK = 8'hB0;

  localparam logic [7:0] ISR_RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [7:0] std_enable_r;
    logic [7:0] oper_enable_r;
    logic [7:0] srq_enable_r;
    logic [7:0] std_event_r;
    logic [7:0] oper_event_r;
    logic [7:0] rdata_r;
    logic [7:0] response_r;
    logic message_avail_r;
    logic power_on_done_r;
    logic mss_prev_r;
    logic request_service_r;
    logic talk_meta_r;
    logic talk_sync_r;
    logic talk_prev_r;
    logic resp_valid_r;
  } isr_state_type;

endpackage

// [core/isr_status.sv]
// status byte, event register sets and service request logic
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [R1] host terminates messages; one strobe is one message
// [R2] read strobe is a query; write is command
// [R3] query alone sends nothing; talk address sends
// [R4] only the latest query response is kept
// [R5] condition register is live, unlatched, read-only
// [R6] standard set lacks condition; operation has all
// [R7] set event bit ignores repeated events
// [R8] event bits clear by query or clear-status
// [R9] summary is OR of event AND enable
// [R10] status byte is combinational, not writable
// [R11] enabled summaries OR into master; raise request
// [R12] status byte query shows master summary bit
// [R13] queries return weighted 8-bit values
// [R14] only enable registers take writes
// [R15] writing zero clears an enable register
// [R16] standard event query reads and clears
// [R17] clear-status clears all event registers
// [R18] exactly two sets feed the status byte
// [R19] standard bits: 7,5,4,2,0 positions
// [R20] status bits: 7,6,5,4 positions
// [R21] serial poll drops request, master stays
// [R22] operation event bits fill positions 7..0
// [R23] reset clears all; unused bits read zero
// [R24] request rises only on master low-to-high
module isr_status
  import isr_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [ISR_ADDR_W-1:0] ADDR,
  input wire logic [ISR_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [ISR_DATA_W-1:0] RDATA,
  input wire logic [7:0] STD_EVENT_IN,
  input wire logic [7:0] OPER_COND_IN,
  input wire logic SERIAL_POLL,
  input wire logic TALK_ADDRESSED,
  output logic [ISR_DATA_W-1:0] RESP_DATA,
  output logic RESP_VALID,
  output logic SRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  isr_state_type st_r;
  isr_state_type st_nxt;
  logic [7:0] oper_cond;
  logic std_summary;
  logic oper_summary;
  logic master_summary;
  logic [7:0] status_byte;
  logic [7:0] query_value;
  logic query_mapped;
  logic std_read_clear;
  logic oper_read_clear;
  logic clear_status;
  logic talk_rise;

  // condition register follows its inputs with no storage
  assign oper_cond = OPER_COND_IN & ISR_OPR_USED_MASK; // [R5] [R6] [R22]

  // only two sets summarise into the byte
  assign std_summary = |(st_r.std_event_r & st_r.std_enable_r); // [R9] [R18]
  assign oper_summary = |(st_r.oper_event_r & st_r.oper_enable_r); // [R9] [R18]

  // message available counts as a summary for the request too
  always_comb begin
    status_byte = ISR_RESET_BYTE;
    status_byte[ISR_STB_OPERATION_SUMMARY] = oper_summary; // [R20] [R10]
    status_byte[ISR_STB_STD_EVENT_SUMMARY] = std_summary; // [R20] [R10]
    status_byte[ISR_STB_MESSAGE_AVAILABLE] = st_r.message_avail_r; // [R20]
  end
  assign master_summary = |(status_byte & st_r.srq_enable_r); // [R11]

  assign clear_status = WR && (ADDR == ISR_OFS_CLEAR_STATUS); // [R17]
  assign std_read_clear = RD && (ADDR == ISR_OFS_STD_EVENT); // [R16]
  assign oper_read_clear = RD && (ADDR == ISR_OFS_OPER_EVENT); // [R8]
  assign talk_rise = st_r.talk_sync_r && !st_r.talk_prev_r; // [R3]

  // query decode; weighting is plain binary so value equals the sum
  always_comb begin
    query_value = ISR_RESET_BYTE;
    query_mapped = 1'b1;
    unique case (ADDR)
      ISR_OFS_STATUS_BYTE: begin
        query_value = status_byte;
        query_value[ISR_STB_MASTER_SUMMARY] = master_summary; // [R12]
      end
      ISR_OFS_STD_EVENT: query_value = st_r.std_event_r; // [R13]
      ISR_OFS_STD_ENABLE: query_value = st_r.std_enable_r;
      ISR_OFS_OPER_EVENT: query_value = st_r.oper_event_r; // [R13]
      ISR_OFS_OPER_COND: query_value = oper_cond; // [R5]
      ISR_OFS_OPER_ENABLE: query_value = st_r.oper_enable_r;
      ISR_OFS_SRQ_ENABLE: query_value = st_r.srq_enable_r;
      default: query_mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.resp_valid_r = 1'b0;
    st_nxt.rdata_r = ISR_RESET_BYTE;

    // talk address is a pin: two flops before use
    st_nxt.talk_meta_r = TALK_ADDRESSED;
    st_nxt.talk_sync_r = st_r.talk_meta_r;
    st_nxt.talk_prev_r = st_r.talk_sync_r;

    // enable registers are the only writable state
    if (WR) begin
      unique case (ADDR)
        ISR_OFS_STD_ENABLE: st_nxt.std_enable_r = WDATA & ISR_STD_USED_MASK; // [R14] [R15]
        ISR_OFS_OPER_ENABLE: st_nxt.oper_enable_r = WDATA & ISR_OPR_USED_MASK; // [R14] [R15]
        ISR_OFS_SRQ_ENABLE: st_nxt.srq_enable_r = WDATA & ISR_SRE_USED_MASK; // [R14] [R15] [R23]
        default: begin
        end
      endcase
    end

    // event registers: clear first, then new events set, so set wins
    if (clear_status || std_read_clear) begin
      st_nxt.std_event_r = ISR_RESET_BYTE; // [R8] [R16] [R17]
    end
    if (clear_status || oper_read_clear) begin
      st_nxt.oper_event_r = ISR_RESET_BYTE; // [R8] [R17]
    end
    st_nxt.std_event_r = st_nxt.std_event_r | (STD_EVENT_IN & ISR_STD_USED_MASK); // [R7] [R19]
    st_nxt.oper_event_r = st_nxt.oper_event_r | oper_cond; // [R7] [R22]

    // power-on event fires once, the cycle after reset release
    st_nxt.power_on_done_r = 1'b1;
    if (!st_r.power_on_done_r) begin
      st_nxt.std_event_r[ISR_STD_POWER_ON] = 1'b1; // [R19]
    end

    // bus answer plus a pending response; a newer query overwrites it
    if (RD) begin
      st_nxt.rdata_r = query_value; // [R13]
      if (query_mapped) begin
        st_nxt.response_r = query_value; // [R2] [R4]
        st_nxt.message_avail_r = 1'b1;
      end
    end

    // response goes out only when addressed as talker
    if (talk_rise && st_r.message_avail_r) begin
      st_nxt.resp_valid_r = 1'b1; // [R3]
      if (!(RD && query_mapped)) begin
        st_nxt.message_avail_r = 1'b0;
      end
    end

    // request line: raised on a rising master bit, dropped by a poll
    st_nxt.mss_prev_r = master_summary;
    if (SERIAL_POLL) begin
      st_nxt.request_service_r = 1'b0; // [R21]
    end
    if (master_summary && !st_r.mss_prev_r) begin
      st_nxt.request_service_r = 1'b1; // [R24] [R11]
    end
  end

  // all state clears at reset; power-on bit follows one cycle later
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      st_r <= '0; // [R23]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA = st_r.rdata_r;
  assign RESP_DATA = st_r.response_r;
  assign RESP_VALID = st_r.resp_valid_r;
  assign SRQ = st_r.request_service_r;

endmodule

`default_nettype wire

// [sim/isr_ctrl_model.sv]
// bus controller model: serial poll and talk address
`timescale 1ns/1ns
`default_nettype none
module isr_ctrl_model (
  input wire logic SYS_CLK,
  input wire logic SRQ,
  output logic serial_poll,
  output logic talk
);
  initial serial_poll = 1'b0;
  initial talk = 1'b0;
  // a real controller polls only once the line is up
  task automatic poll();
    @(posedge SYS_CLK);
    serial_poll <= SRQ;
    @(posedge SYS_CLK);
    serial_poll <= 1'b0;
  endtask
  task automatic address_talk();
    @(posedge SYS_CLK);
    talk <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [sim/isr_status_assertions.sv]
// port checker for the status reporting block
`timescale 1ns/1ns
`default_nettype none
module isr_status_chk (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] STD_EVENT_IN,
  input wire logic [7:0] OPER_COND_IN,
  input wire logic SERIAL_POLL,
  input wire logic TALK_ADDRESSED,
  input wire logic [7:0] RESP_DATA,
  input wire logic RESP_VALID,
  input wire logic SRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not idle");
  cond_live_a: assert property ($past(RD) && $past(ADDR) == 3'h4 |-> RDATA == $past(OPER_COND_IN))
    else $error("condition not live");
  std_unused_a: assert property ($past(RD) && $past(ADDR) == 3'h1 |-> (RDATA & 8'h4A) == 8'h00)
    else $error("unused event bit set");
  sre_unused_a: assert property ($past(RD) && $past(ADDR) == 3'h6 |-> (RDATA & 8'h4F) == 8'h00)
    else $error("unused enable bit set");
  master_cause_a: assert property ($past(RD) && $past(ADDR) == 3'h0 && RDATA[6] |-> |RDATA[5:4] || RDATA[7])
    else $error("master bit without summary");
  poll_drop_a: assert property (SERIAL_POLL && SRQ |=> !SRQ)
    else $error("request kept after poll");
  resp_talk_a: assert property (RESP_VALID |-> $past(TALK_ADDRESSED, 3) && !$past(TALK_ADDRESSED, 4))
    else $error("response without talk");
  read_clear_a: assert property ($past(RD, 2) && $past(RD) && $past(ADDR, 2) == 3'h1 && $past(ADDR) == 3'h1
    && $past(STD_EVENT_IN, 2) == 8'h00 |-> RDATA == 8'h00)
    else $error("event kept after read");
endmodule
`default_nettype wire

// [sim/isr_status_bench.sv]
// self-checking bench for the status reporting block
`timescale 1ns/1ns
`default_nettype none
module isr_status_bench;
  logic clk, rstn, wr, rd, poll, talk, resp_valid, srq;
  logic [2:0] addr;
  logic [7:0] wdata, std_ev, oper_c, rdata, resp_data, v;
  int error_cnt = 0;
  int tests_run = 0;
  logic seen;
  int n;
  logic [18:0] rows [6] = '{{3'h2, 8'hFF, 8'hB5}, {3'h5, 8'hA5, 8'hA5}, {3'h6, 8'hFF, 8'hB0},
    {3'h6, 8'h00, 8'h00}, {3'h2, 8'h00, 8'h00}, {3'h1, 8'hFF, 8'h00}};
  isr_status dut (.SYS_CLK(clk), .RESETN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .STD_EVENT_IN(std_ev), .OPER_COND_IN(oper_c), .SERIAL_POLL(poll),
    .TALK_ADDRESSED(talk), .RESP_DATA(resp_data), .RESP_VALID(resp_valid), .SRQ(srq));
  isr_ctrl_model ctrl (.SYS_CLK(clk), .SRQ(srq), .serial_poll(poll), .talk(talk));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  // one strobe carries one whole terminated message
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse(input logic [7:0] s, input logic [7:0] o);
    @(posedge clk);
    std_ev <= s;
    oper_c <= o;
    @(posedge clk);
    std_ev <= 8'h00;
    oper_c <= 8'h00;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rstn, wr, rd, addr, wdata, std_ev, oper_c} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // two reads back to back: the second one sees the cleared register
    @(posedge clk);
    rd <= 1'b1;
    addr <= 3'h1;
    @(posedge clk);
    #1 chk("power on", rdata, 8'h80);
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("read clear", rdata, 8'h00);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][18:16], rows[i][15:8]);
      bus(1'b0, rows[i][18:16], 8'h00);
      chk("enable row", v, rows[i][7:0]);
    end
    $display("register rows done");
    bus(1'b1, 3'h2, 8'h20);
    bus(1'b1, 3'h6, 8'h20);
    pulse(8'h20, 8'h00);
    @(posedge clk);
    #1 chk("request", srq, 1'b1);
    pulse(8'h20, 8'h00);
    ctrl.poll();
    #1 chk("poll drop", srq, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk("no rearm", srq, 1'b0);
    bus(1'b0, 3'h0, 8'h00);
    chk("status byte", v & 8'hEF, 8'h60);
    bus(1'b0, 3'h1, 8'h00);
    chk("event read", v, 8'h20);
    bus(1'b0, 3'h0, 8'h00);
    chk("summary clear", v & 8'hEF, 8'h00);
    $display("service request done");
    pulse(8'h00, 8'h11);
    bus(1'b0, 3'h3, 8'h00);
    chk("oper latch", v, 8'h11);
    pulse(8'h01, 8'h81);
    bus(1'b1, 3'h7, 8'h00);
    bus(1'b0, 3'h3, 8'h00);
    chk("clear oper", v, 8'h00);
    bus(1'b0, 3'h1, 8'h00);
    chk("clear std", v, 8'h00);
    @(posedge clk);
    oper_c <= 8'h3C;
    bus(1'b0, 3'h4, 8'h00);
    chk("condition", v, 8'h3C);
    @(posedge clk);
    oper_c <= 8'h00;
    bus(1'b1, 3'h6, 8'h10);
    bus(1'b0, 3'h6, 8'h00);
    bus(1'b0, 3'h2, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk("no talk", resp_valid, 1'b0);
    ctrl.address_talk();
    // bounded wait; a pulse that never comes shows up as a mismatch
    seen = 1'b0;
    n = 0;
    while (n < 10 && seen !== 1'b1) begin
      @(posedge clk);
      #1 seen = resp_valid;
      n++;
    end
    chk("response valid", {7'h00, seen}, 8'h01);
    chk("talk delay", n[7:0], 8'h03);
    chk("response", resp_data, 8'h20);
    $display("response done");
    final_report();
  end
endmodule
bind isr_status isr_status_chk chk (.*);
`default_nettype wire
